/* File: common/ms_pkg.sv */
// Shared constants and types for the measurement supervisor.
// Assumes a single 100 MHz system clock and readings in 0.1 megohm units.
`default_nettype none
package ms_pkg;
   localparam int          CLK_HZ      = 100_000_000;
   // Reset key hold time in seconds and its cycle count.
   localparam int          KEY_HOLD_S  = 3;
   localparam int          KEY_HOLD_DEF = KEY_HOLD_S * CLK_HZ;
   // Slowest accepted repetition rate of line voltage peaks.
   localparam int          PEAK_MIN_HZ = 20;
   localparam int          PEAK_GAP_DEF = CLK_HZ / PEAK_MIN_HZ;
   // Over-range flash rate of the display, in full on/off periods.
   localparam int          BLINK_HZ    = 2;
   localparam int          BLINK_DEF   = CLK_HZ / (2 * BLINK_HZ);
   localparam int          CNT_W       = 32;
   localparam logic [31:0] CNT_ZERO    = 32'h0000_0000;
   localparam logic [31:0] CNT_ONE     = 32'h0000_0001;

   // Readings are in 0.1 megohm steps: 1 is 0.1, 999 is 99.9.
   localparam int          RD_W        = 10;
   localparam logic [9:0]  RD_MIN      = 10'h001;
   localparam logic [9:0]  RD_MAX      = 10'h3E7;
   localparam logic [9:0]  RD_ZERO     = 10'h000;

   // Line samples are signed, in 0.1 V units; 200 is 20.0 V.
   localparam int          VS_W        = 16;
   localparam logic [15:0] VOLT_THR    = 16'h00C8;

   typedef enum logic [1:0] {
      MS_LVL_OPER = 2'h0,
      MS_LVL_INIT = 2'h1,
      MS_LVL_COMM = 2'h2,
      MS_LVL_PROT = 2'h3
   } ms_level_t;

   typedef enum logic [3:0] {
      MS_IDLE = 4'h1,
      MS_AUTO = 4'h2,
      MS_MAN  = 4'h4,
      MS_HOLD = 4'h8
   } ms_state_t;

   typedef struct packed {
      logic [9:0] value;
      logic       valid;
      logic       under;
      logic       over_on;
   } ms_disp_t;

   typedef struct packed {
      logic alarm;
      logic alarm_led;
      logic failed;
      logic test_volt;
      logic auto_run;
      logic manual_run;
   } ms_stat_t;
endpackage
`default_nettype wire

/* File: rtl/ms_supervisor.sv */
// Supervisor for an insulation-resistance measurement unit: load voltage
// watch, limiter trip, reset key, range clamp and measurement control.
// Assumes trigger, reset key and limiter come from pins; the rest is logic
// on the same clock.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Readings clamp for alarm judgment: below 0.1 to zero, above 99.9 to 99.9.
// - Display shows steady under-range below 0.1, flashing over-range above 99.9.
// - While the load is powered, neither trigger nor manual start begins measuring.
// - Load becoming powered during a measurement ends it at once.
// - Load powered after trigger on marks measurement failed and sets alarm.
// - Load is powered when absolute line peak exceeds about 20 volts.
// - Peaks must recur at 20 Hz or faster, else load may read unpowered.
// - Limiter trip stops measuring and disconnects from the load at once.
// - Limiter trip in automatic measurement also marks it failed and sets the alarm.
// - Reset key held three seconds in operation level performs full reset.
// - Reset clears confirmed values, alarm outputs and the alarm indicator.
// - Reset ends any automatic or manual measurement immediately.
// - Communications reset command performs the same reset as the reset key, but in every level and with no hold time.
// - Reset key is ignored in initial, communications and protect levels.
// - Manual measurement error stops test voltage, shows failure, holds there.
module ms_supervisor
   import ms_pkg::*;
#(
   parameter logic [31:0] KEY_HOLD_CYC = 32'(KEY_HOLD_DEF),
   parameter logic [31:0] PEAK_GAP_CYC = 32'(PEAK_GAP_DEF),
   parameter logic [31:0] BLINK_CYC    = 32'(BLINK_DEF)
) (
   input  wire logic            clock,
   input  wire logic            nrst,
   input  wire logic            trigger_pin,
   input  wire logic            reset_key_n,
   input  wire logic            limiter_pin,
   input  wire logic [VS_W-1:0] line_sample,
   input  wire ms_level_t       level,
   input  wire logic            manual_start,
   input  wire logic            manual_stop,
   input  wire logic            comm_reset,
   input  wire logic            meas_done,
   input  wire logic [RD_W-1:0] reading,
   input  wire logic [RD_W-1:0] alarm_limit,
   output var  ms_disp_t        disp,
   output var  ms_stat_t        stat,
   output var  logic            load_powered,
   output var  logic [RD_W-1:0] judged_value
);

   // Clamp a raw reading to the range used for alarm judgment.
   function automatic logic [RD_W-1:0] ms_judge(input logic [RD_W-1:0] r);
      if (r < RD_MIN) begin
         ms_judge = RD_ZERO;
      end else if (r > RD_MAX) begin
         ms_judge = RD_MAX;
      end else begin
         ms_judge = r;
      end
   endfunction

   // Pin synchronisers: only the second stage is read by logic.
   logic [2:0] sy1_r;
   logic [2:0] sy2_r;
   logic       trig_s;
   logic       key_s;
   logic       lim_s;
   logic       trig_d_r;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         sy1_r    <= 3'h0;
         sy2_r    <= 3'h0;
         trig_d_r <= 1'b0;
      end else begin
         sy1_r    <= {limiter_pin, ~reset_key_n, trigger_pin};
         sy2_r    <= sy1_r;
         trig_d_r <= trig_s;
      end
   end

   assign trig_s = sy2_r[0];
   assign key_s  = sy2_r[1];
   assign lim_s  = sy2_r[2];

   // Load voltage monitor. A peak above threshold restarts a hold window one
   // slowest-peak period long, so slower AC reads as unpowered between peaks.
   logic [VS_W-1:0]  abs_v;
   logic             above;
   logic [CNT_W-1:0] vm_cnt_r;
   logic [CNT_W-1:0] vm_cnt_nxt;
   logic             powered_r;
   logic             powered_nxt;

   always_comb begin
      abs_v       = line_sample[VS_W-1] ? VS_W'(-line_sample) : line_sample;
      above       = abs_v > VOLT_THR;
      vm_cnt_nxt  = vm_cnt_r;
      if (above) begin
         vm_cnt_nxt = PEAK_GAP_CYC;
      end else if (vm_cnt_r != CNT_ZERO) begin
         vm_cnt_nxt = vm_cnt_r - CNT_ONE;
      end
      powered_nxt = above || (vm_cnt_r > CNT_ONE);
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         vm_cnt_r  <= CNT_ZERO;
         powered_r <= 1'b0;
      end else begin
         vm_cnt_r  <= vm_cnt_nxt;
         powered_r <= powered_nxt;
      end
   end

   // Reset key hold timer; it saturates so a long press fires only once.
   logic [CNT_W-1:0] key_cnt_r;
   logic [CNT_W-1:0] key_cnt_nxt;
   logic             lvl_op;
   logic             key_fire;
   logic             reset_ev;

   always_comb begin
      lvl_op      = (level == MS_LVL_OPER);
      key_cnt_nxt = key_cnt_r;
      if (!(key_s && lvl_op)) begin
         key_cnt_nxt = CNT_ZERO;
      end else if (key_cnt_r != KEY_HOLD_CYC) begin
         key_cnt_nxt = key_cnt_r + CNT_ONE;
      end
      key_fire = key_s && lvl_op && (key_cnt_r == KEY_HOLD_CYC - CNT_ONE);
      reset_ev = key_fire || comm_reset;
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         key_cnt_r <= CNT_ZERO;
      end else begin
         key_cnt_r <= key_cnt_nxt;
      end
   end

   // Measurement control, confirmed result and alarm state.
   ms_state_t       st_r;
   ms_state_t       st_nxt;
   ms_stat_t        stat_nxt;
   logic [RD_W-1:0] conf_raw_r;
   logic [RD_W-1:0] conf_raw_nxt;
   logic            conf_vld_r;
   logic            conf_vld_nxt;
   logic            start_ok;
   logic            abort;
   logic            running;
   logic            trig_ev;
   logic            fail_ev;

   always_comb begin
      st_nxt       = st_r;
      stat_nxt     = stat;
      conf_raw_nxt = conf_raw_r;
      conf_vld_nxt = conf_vld_r;
      start_ok     = lvl_op && !powered_r;
      abort        = powered_r || lim_s;
      running      = (st_r == MS_AUTO) || (st_r == MS_MAN);
      trig_ev      = trig_s && !trig_d_r && lvl_op;
      fail_ev      = ((st_r == MS_AUTO) && abort)
                  || ((st_r == MS_IDLE) && trig_ev && !start_ok);
      if (reset_ev) begin
         st_nxt             = MS_IDLE;
         conf_vld_nxt       = 1'b0;
         conf_raw_nxt       = RD_ZERO;
         stat_nxt.alarm     = 1'b0;
         stat_nxt.alarm_led = 1'b0;
         stat_nxt.failed    = 1'b0;
         // A failure in the same cycle still wins over the clear.
         if (fail_ev) begin
            stat_nxt.alarm     = 1'b1;
            stat_nxt.alarm_led = 1'b1;
            stat_nxt.failed    = 1'b1;
         end
      end else begin
         case (st_r)
            MS_IDLE: begin
               if (trig_ev) begin
                  if (start_ok) begin
                     st_nxt = MS_AUTO;
                  end else begin
                     stat_nxt.failed    = 1'b1;
                     stat_nxt.alarm     = 1'b1;
                     stat_nxt.alarm_led = 1'b1;
                  end
               end else if (manual_start && start_ok) begin
                  st_nxt             = MS_MAN;
                  conf_vld_nxt       = 1'b0;
                  stat_nxt.alarm     = 1'b0;
                  stat_nxt.alarm_led = 1'b0;
                  stat_nxt.failed    = 1'b0;
               end
            end
            MS_AUTO: begin
               if (abort) begin
                  st_nxt             = MS_IDLE;
                  stat_nxt.failed    = 1'b1;
                  stat_nxt.alarm     = 1'b1;
                  stat_nxt.alarm_led = 1'b1;
               end else if (meas_done) begin
                  st_nxt       = MS_IDLE;
                  conf_raw_nxt = reading;
                  conf_vld_nxt = 1'b1;
                  if (ms_judge(reading) < alarm_limit) begin
                     stat_nxt.alarm     = 1'b1;
                     stat_nxt.alarm_led = 1'b1;
                  end
               end
            end
            MS_MAN: begin
               if (abort) begin
                  st_nxt          = MS_HOLD;
                  stat_nxt.failed = 1'b1;
               end else if (manual_stop) begin
                  st_nxt = MS_IDLE;
               end else if (meas_done) begin
                  conf_raw_nxt = reading;
                  conf_vld_nxt = 1'b1;
               end
            end
            MS_HOLD: begin
               if (manual_stop) begin
                  st_nxt          = MS_IDLE;
                  stat_nxt.failed = 1'b0;
               end
            end
            default: begin
               st_nxt = MS_IDLE;
            end
         endcase
      end
      stat_nxt.test_volt  = (st_nxt == MS_AUTO) || (st_nxt == MS_MAN);
      stat_nxt.auto_run   = (st_nxt == MS_AUTO);
      stat_nxt.manual_run = (st_nxt == MS_MAN);
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         st_r       <= MS_IDLE;
         stat       <= '0;
         conf_raw_r <= RD_ZERO;
         conf_vld_r <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         stat       <= stat_nxt;
         conf_raw_r <= conf_raw_nxt;
         conf_vld_r <= conf_vld_nxt;
      end
   end

   // Display and judged value, registered from the confirmed reading.
   logic [CNT_W-1:0] bl_cnt_r;
   logic [CNT_W-1:0] bl_cnt_nxt;
   logic             bl_ph_r;
   logic             bl_ph_nxt;
   ms_disp_t         disp_nxt;
   logic [RD_W-1:0]  judged_nxt;

   always_comb begin
      bl_cnt_nxt = bl_cnt_r + CNT_ONE;
      bl_ph_nxt  = bl_ph_r;
      if (bl_cnt_r >= BLINK_CYC - CNT_ONE) begin
         bl_cnt_nxt = CNT_ZERO;
         bl_ph_nxt  = ~bl_ph_r;
      end
      judged_nxt       = ms_judge(conf_raw_r);
      disp_nxt.valid   = conf_vld_r;
      disp_nxt.value   = judged_nxt;
      disp_nxt.under   = conf_vld_r && (conf_raw_r < RD_MIN);
      disp_nxt.over_on = conf_vld_r && (conf_raw_r > RD_MAX) && bl_ph_r;
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         bl_cnt_r     <= CNT_ZERO;
         bl_ph_r      <= 1'b0;
         disp         <= '0;
         judged_value <= RD_ZERO;
         load_powered <= 1'b0;
      end else begin
         bl_cnt_r     <= bl_cnt_nxt;
         bl_ph_r      <= bl_ph_nxt;
         disp         <= disp_nxt;
         judged_value <= judged_nxt;
         load_powered <= powered_nxt;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   property p_no_start_powered;
      (st_r == MS_IDLE) && powered_r |=> !stat.test_volt;
   endproperty
   a_no_start_powered: assert property (p_no_start_powered)
      else $error("measurement started while load powered");

   property p_abort_powered;
      running && powered_r |=> !stat.test_volt ##1 !stat.test_volt;
   endproperty
   a_abort_powered: assert property (p_abort_powered)
      else $error("measurement kept running with load powered");

   property p_fail_alarm;
      (st_r == MS_AUTO) && powered_r |=> stat.failed && stat.alarm;
   endproperty
   a_fail_alarm: assert property (p_fail_alarm)
      else $error("load powered in auto run without failure alarm");

   property p_thresh;
      (abs_v > VOLT_THR) |=> powered_r ##1 load_powered;
   endproperty
   a_thresh: assert property (p_thresh)
      else $error("peak above threshold not judged powered");

   property p_lim_alarm;
      (st_r == MS_AUTO) && lim_s |=> !stat.test_volt && stat.alarm_led;
   endproperty
   a_lim_alarm: assert property (p_lim_alarm)
      else $error("limiter trip did not stop and alarm");

   property p_reset_clear;
      key_fire && !fail_ev |=> !stat.alarm && !conf_vld_r
         && (st_r == MS_IDLE);
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("reset key did not clear results");

   property p_comm_reset;
      comm_reset |=> (st_r == MS_IDLE) && !stat.test_volt;
   endproperty
   a_comm_reset: assert property (p_comm_reset)
      else $error("communications reset did not end measurement");

   // The key is level-gated and the communications reset is not, so outside operation an alarm may fall
   // only through a communications reset.
   property p_key_level;
      !lvl_op && !comm_reset && stat.alarm |=> stat.alarm;
   endproperty
   a_key_level: assert property (p_key_level)
      else $error("reset key acted outside operation level");

   property p_man_hold;
      (st_r == MS_MAN) && abort && !reset_ev |=> (st_r == MS_HOLD)
         && stat.failed && !stat.test_volt;
   endproperty
   a_man_hold: assert property (p_man_hold)
      else $error("manual error did not enter held failure");

   property p_key_release;
      !key_s |=> key_cnt_r == CNT_ZERO;
   endproperty
   a_key_release: assert property (p_key_release)
      else $error("key counter not cleared on release");

   property p_over_clamp;
      conf_vld_r && (conf_raw_r > RD_MAX) && $stable(conf_raw_r)
         |=> judged_value == RD_MAX && !disp.under;
   endproperty
   a_over_clamp: assert property (p_over_clamp)
      else $error("over-range reading not clamped");

   c_auto_done: cover property ((st_r == MS_AUTO) && meas_done);
   c_auto_fail: cover property ((st_r == MS_AUTO) ##1 stat.failed);
   c_key_reset: cover property (key_fire);
   c_man_hold:  cover property (st_r == MS_HOLD);
endmodule
`default_nettype wire

/* File: tb/ms_line_model.sv */
// Model of the load power line and the operator reset key.
// Assumes the bench changes its commands just after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module ms_line_model
   import ms_pkg::*;
(
   input  wire logic            clock,
   input  wire logic            load_on,
   input  wire logic            key_down,
   output var  logic [VS_W-1:0] line_sample,
   output var  logic            reset_key_n
);
   logic [2:0] ph_r = 3'h0;

   always_ff @(posedge clock) begin
      ph_r <= ph_r + 3'h1;
   end

   // A powered line peaks at 30 V with both signs, well above 20 Hz.
   // An unpowered line sits exactly on 20 V, which must not count.
   always_comb begin
      if (load_on) begin
         line_sample = (ph_r == 3'h0) ? 16'h012C :
                       (ph_r == 3'h4) ? 16'hFED4 : 16'h0032;
      end else begin
         line_sample = ph_r[0] ? 16'h00C8 : 16'hFF38;
      end
   end

   assign reset_key_n = !key_down;
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the measurement supervisor.
// Assumes shortened key, peak gap and blink counts set below.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import ms_pkg::*;
;
   logic            clock = 1'b0;
   logic            nrst;
   logic            trigger_pin;
   logic            limiter_pin;
   logic            load_on;
   logic            key_down;
   logic            reset_key_n;
   logic [VS_W-1:0] line_sample;
   ms_level_t       level;
   logic            manual_start;
   logic            manual_stop;
   logic            comm_reset;
   logic            meas_done;
   logic [RD_W-1:0] reading;
   logic [RD_W-1:0] alarm_limit;
   ms_disp_t        disp;
   ms_stat_t        stat;
   logic            load_powered;
   logic [RD_W-1:0] judged_value;
   int              n_fail = 0;
   int              checked = 0;

   ms_supervisor #(
      .KEY_HOLD_CYC (32'h0000_0014),
      .PEAK_GAP_CYC (32'h0000_0010),
      .BLINK_CYC    (32'h0000_0004)
   ) dut (
      .clock(clock), .nrst(nrst), .trigger_pin(trigger_pin),
      .reset_key_n(reset_key_n), .limiter_pin(limiter_pin),
      .line_sample(line_sample), .level(level),
      .manual_start(manual_start), .manual_stop(manual_stop),
      .comm_reset(comm_reset), .meas_done(meas_done), .reading(reading),
      .alarm_limit(alarm_limit), .disp(disp), .stat(stat),
      .load_powered(load_powered), .judged_value(judged_value)
   );

   ms_line_model line (
      .clock(clock), .load_on(load_on), .key_down(key_down),
      .line_sample(line_sample), .reset_key_n(reset_key_n)
   );

   always #5 clock = !clock;

   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      if (n_fail == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic trig();
      trigger_pin = 1'b1;
      step(6);
      trigger_pin = 1'b0;
   endtask

   task automatic man(input logic s);
      manual_start = s;
      manual_stop = !s;
      step(1);
      manual_start = 1'b0;
      manual_stop = 1'b0;
   endtask

   task automatic key(input int n);
      key_down = 1'b1;
      step(n);
      key_down = 1'b0;
      step(4);
   endtask

   task automatic clr();
      comm_reset = 1'b1;
      step(1);
      comm_reset = 1'b0;
      step(2);
      chk({stat.alarm, stat.alarm_led, stat.failed}, 3'h0);
      chk(judged_value, 10'h000);
   endtask

   task automatic run_auto(input logic [9:0] rd);
      trig();
      chk(stat.auto_run, 1'b1);
      reading = rd;
      meas_done = 1'b1;
      step(1);
      meas_done = 1'b0;
      step(3);
      chk(stat.auto_run, 1'b0);
   endtask

   task automatic t_range();
      int n;
      n = 0;
      alarm_limit = 10'h3E8;
      run_auto(10'h3E8);
      chk({judged_value, disp.value}, {10'h3E7, 10'h3E7});
      chk(stat.alarm, 1'b1);
      for (int i = 0; i < 16; i++) begin
         n += int'(disp.over_on);
         step(1);
      end
      chk(n > 0 && n < 16, 1'b1);
      run_auto(10'h001);
      chk({judged_value, disp.under}, {10'h001, 1'b0});
      run_auto(10'h000);
      chk(judged_value, 10'h000);
      chk({disp.under, disp.over_on}, 2'h2);
      chk(stat.alarm, 1'b1);
   endtask

   task automatic t_power();
      clr();
      load_on = 1'b1;
      step(4);
      chk(load_powered, 1'b1);
      trig();
      step(2);
      chk(stat.auto_run, 1'b0);
      chk({stat.failed, stat.alarm}, 2'h3);
      man(1'b1);
      step(2);
      chk(stat.manual_run, 1'b0);
      load_on = 1'b0;
      step(20);
      chk(load_powered, 1'b0);
   endtask

   task automatic t_abort(input logic lim);
      clr();
      trig();
      chk(stat.auto_run, 1'b1);
      limiter_pin = lim;
      load_on = !lim;
      step(5);
      chk(stat.auto_run, 1'b0);
      chk(stat.test_volt, 1'b0);
      chk({stat.failed, stat.alarm, stat.alarm_led}, 3'h7);
      limiter_pin = 1'b0;
      load_on = 1'b0;
      step(20);
      chk(load_powered, 1'b0);
   endtask

   task automatic t_manual();
      clr();
      man(1'b1);
      step(1);
      chk({stat.manual_run, stat.test_volt}, 2'h3);
      limiter_pin = 1'b1;
      step(5);
      limiter_pin = 1'b0;
      step(5);
      chk({stat.manual_run, stat.test_volt}, 2'h0);
      chk(stat.failed, 1'b1);
      man(1'b0);
      step(2);
      chk(stat.failed, 1'b0);
      man(1'b1);
      reading = 10'h005;
      meas_done = 1'b1;
      step(1);
      meas_done = 1'b0;
      step(2);
      chk({judged_value, stat.alarm}, {10'h005, 1'b0});
      man(1'b0);
      step(1);
      chk(stat.manual_run, 1'b0);
      man(1'b1);
      step(2);
      clr();
      chk(stat.manual_run, 1'b0);
   endtask

   task automatic t_key();
      run_auto(10'h000);
      key(10);
      chk(stat.alarm, 1'b1);
      for (int i = 1; i < 4; i++) begin
         level = ms_level_t'(i);
         key(30);
         chk(stat.alarm, 1'b1);
      end
      level = MS_LVL_OPER;
      trig();
      key(30);
      chk({stat.auto_run, stat.test_volt}, 2'h0);
      chk({stat.alarm, stat.alarm_led}, 2'h0);
      chk({judged_value, disp.valid}, 11'h000);
   endtask

   initial begin
      nrst = 1'b0;
      {trigger_pin, limiter_pin, load_on, key_down} = 4'h0;
      {manual_start, manual_stop, comm_reset, meas_done} = 4'h0;
      level = MS_LVL_OPER;
      reading = 10'h000;
      alarm_limit = 10'h000;
      step(2);
      nrst = 1'b1;
      step(1);
      chk({stat, load_powered, judged_value}, 17'h00000);
      t_range();
      t_power();
      t_abort(1'b0);
      t_abort(1'b1);
      t_manual();
      t_key();
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      end_of_test();
   end
endmodule
`default_nettype wire
